// ### rtl/sipo_fifo.sv
`timescale 1ns/100ps
module sipo_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8,
    parameter int PTR_W = 3
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_W-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
    logic [PTR_W:0] count, next_count;
    logic push, pop;

    assign in_ready = (count != (PTR_W+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data = mem[rd_ptr];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
        next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
        next_count = count;
        if (push && !pop) begin
            next_count = count + 1'b1;
        end else if (pop && !push) begin
            next_count = count - 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
        end
    end

    // storage needs no reset; empty flag guards stale words
    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end
endmodule : sipo_fifo

// ### rtl/sipo_latch.sv
`timescale 1ns/100ps
// Summary of operation
// - each rising shift clock edge moves serial data into stage one and every stage into the next.
// - the final stage is driven on the cascade output to feed a following device.
// - at a rising clock edge the seventh stage loads the eighth and shows on the cascade output.
// - the cascade value is copied to a delayed cascade output on the following falling clock edge.
// - each stage feeds one latch bit, and the latch holds on the falling edge of the strobe.
// - while the strobe is high the latch passes the stages through; while low it holds.
// - parallel outputs are driven only while output enable is high, otherwise released.
module sipo_latch
    import sipo_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // controller pins
    input wire logic ser_data,
    input wire logic shift_clk,
    input wire logic strobe,
    input wire logic out_enable,
    // cascade outputs
    output logic final_stage,
    output logic final_stage_delayed,
    // parallel outputs, three-state as value plus enable
    output logic [STAGES-1:0] parallel_out,
    output logic [STAGES-1:0] parallel_oe,
    // latched words as a stream, one per strobe fall
    output logic word_valid,
    input wire logic word_ready,
    output logic [STAGES-1:0] word_data,
    output logic word_overflow
);

    // pin bank, in ascending bit order: ser_data, shift_clk, strobe, out_enable
    localparam int N_PINS = 4;

    // synchronised pin levels
    logic [N_PINS-1:0] pin_raw;
    logic [N_PINS-1:0] pin_sync;
    logic data_s;
    logic clk_s;
    logic stb_s;
    logic oe_s;

    // edge history, one cycle behind the synchronised levels
    logic clk_prev;
    logic stb_prev;
    logic next_clk_prev;
    logic next_stb_prev;
    logic clk_rise;
    logic clk_fall;
    logic stb_fall;

    // shift register, delayed cascade copy and storage latch
    logic [STAGES-1:0] stage;
    logic [STAGES-1:0] next_stage;
    logic casc_dly;
    logic next_casc_dly;
    logic [STAGES-1:0] held;
    logic [STAGES-1:0] next_held;

    // word stream bookkeeping
    logic ovf;
    logic next_ovf;
    logic fifo_ready;

    // edge decode from a level and its value one cycle earlier
    function automatic logic edge_up(input logic lvl, input logic lvl_prev);
        return lvl && !lvl_prev;
    endfunction : edge_up

    function automatic logic edge_down(input logic lvl, input logic lvl_prev);
        return !lvl && lvl_prev;
    endfunction : edge_down

    // every pin is asynchronous to core_clk, so none is read before its second flop;
    // a level must stand one full core cycle to be seen, so pin pulses shorter
    // than that are lost rather than half-taken
    assign pin_raw = {out_enable, strobe, shift_clk, ser_data};

    for (genvar gi = 0; gi < N_PINS; gi++) begin : g_sync
        logic meta;
        logic sync;
        logic next_meta;
        logic next_sync;

        always_comb begin
            next_meta = pin_raw[gi];
            next_sync = meta;
        end

        always_ff @(posedge core_clk) begin
            if (sys_rst) begin
                meta <= SYNC_RST[0];
                sync <= SYNC_RST[1];
            end else begin
                meta <= next_meta;
                sync <= next_sync;
            end
        end

        assign pin_sync[gi] = sync;
    end

    // data and clock share one synchroniser depth, so data must settle a core
    // cycle ahead of the shift clock edge to be taken with it
    assign {oe_s, stb_s, clk_s, data_s} = pin_sync;

    // edge history resets to the idle pin level, so no false edge follows reset
    always_comb begin
        next_clk_prev = clk_s;
        next_stb_prev = stb_s;
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            clk_prev <= SYNC_RST[1];
            stb_prev <= SYNC_RST[1];
        end else begin
            clk_prev <= next_clk_prev;
            stb_prev <= next_stb_prev;
        end
    end

    assign clk_rise = edge_up(clk_s, clk_prev);
    assign clk_fall = edge_down(clk_s, clk_prev);
    assign stb_fall = edge_down(stb_s, stb_prev);

    // shift register; the last stage doubles as the cascade output, so the
    // cascade value changes on the very edge that loads the eighth stage
    always_comb begin
        next_stage = stage;
        if (clk_rise) begin
            next_stage = {stage[STAGES-2:0], data_s};
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            stage <= STAGE_RST;
        end else begin
            stage <= next_stage;
        end
    end

    // delayed cascade copy, taken on the falling shift clock edge; a chained
    // device then sees half a shift period of hold on its serial input
    always_comb begin
        next_casc_dly = casc_dly;
        if (clk_fall) begin
            next_casc_dly = stage[STAGES-1];
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            casc_dly <= STAGE_RST[STAGES-1];
        end else begin
            casc_dly <= next_casc_dly;
        end
    end

    // storage latch as a clocked stand-in: it copies the stages while the strobe
    // is high and keeps the last copy once the strobe falls; it trails the stages
    // by one core cycle, traded for a glitch-free output with no real latch
    always_comb begin
        next_held = held;
        if (stb_s) begin
            next_held = stage;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            held <= STAGE_RST;
        end else begin
            held <= next_held;
        end
    end

    // a strobe fall that meets a full stream sets a sticky flag; only reset clears
    // it, so a reader can still tell afterwards that a word went missing
    always_comb begin
        next_ovf = ovf;
        if (stb_fall && !fifo_ready) begin
            next_ovf = 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            ovf <= 1'b0;
        end else begin
            ovf <= next_ovf;
        end
    end

    // the enable gates only the parallel drivers, never the shift or cascade path
    assign final_stage = stage[STAGES-1];
    assign final_stage_delayed = casc_dly;
    assign parallel_out = held;
    assign parallel_oe = {STAGES{oe_s}};
    assign word_overflow = ovf;

    // a word lost when the stream is full is flagged, not stalled: the pins cannot wait
    sipo_fifo #(
        .WIDTH(STAGES),
        .DEPTH(FIFO_DEPTH),
        .PTR_W(FIFO_PTR_W)
    ) u_fifo (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .in_valid(stb_fall),
        .in_ready(fifo_ready),
        .in_data(held),
        .out_valid(word_valid),
        .out_ready(word_ready),
        .out_data(word_data)
    );
endmodule : sipo_latch

// ### rtl/sipo_pkg.sv
package sipo_pkg;
    localparam int STAGES = 8;
    localparam int FIFO_DEPTH = 8;
    localparam int FIFO_PTR_W = 3;
    localparam logic [STAGES-1:0] STAGE_RST = 8'h00;
    localparam logic [FIFO_PTR_W:0] FIFO_CNT_RST = 4'h0;
    localparam logic [1:0] SYNC_RST = 2'h0;
endpackage : sipo_pkg

// ### testbench/sipo_host.sv
`timescale 1ns/100ps
module sipo_host (
    input wire logic core_clk,
    output logic ser_data,
    output logic shift_clk,
    output logic strobe
);
    initial {ser_data, shift_clk, strobe} = 3'h0;
    // every level held six cycles so the synchroniser never misses one
    task automatic step(input logic [2:0] v);
        {ser_data, shift_clk, strobe} <= v;
        repeat (6) @(posedge core_clk);
    endtask : step
    task automatic send(input logic [7:0] b, input logic s);
        for (int i = 7; i >= 0; i--) begin
            step({b[i], 2'h0});
            step({b[i], 2'h2});
        end
        step({2'h0, s});
        step(3'h0);
    endtask : send
endmodule : sipo_host

// ### testbench/sipo_latch_monitor.sv
`timescale 1ns/100ps
module sipo_mon
    import sipo_pkg::*;
(
    // pins and outputs watched
    input logic core_clk, sys_rst, shift_clk, strobe, out_enable, final_stage,
    input logic final_stage_delayed, word_valid, word_ready, word_overflow,
    input logic [STAGES-1:0] parallel_out, parallel_oe, word_data
);
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);
    oe_on_a: assert property ($rose(out_enable) |-> ##3 &parallel_oe) else $error("oe");
    oe_off_a: assert property ($fell(out_enable) |-> ##3 !parallel_oe) else $error("oe");
    shift_time_a: assert property ($changed(final_stage) |->
        $past(shift_clk, 3) && !$past(shift_clk, 5)) else $error("shift");
    dly_time_a: assert property ($changed(final_stage_delayed) |->
        !$past(shift_clk, 3) && $past(shift_clk, 5)) else $error("delayed");
    dly_copy_a: assert property ($fell(shift_clk) |->
        ##4 final_stage_delayed == final_stage) else $error("copy");
    latch_hold_a: assert property ($changed(parallel_out) |->
        $past(strobe, 3) || $past(strobe, 5)) else $error("latch");
    word_hold_a: assert property (word_valid && !word_ready |=>
        word_valid && $stable(word_data)) else $error("word");
    ovf_stick_a: assert property (word_overflow |=> word_overflow) else $error("ovf");
    cover property (word_overflow);
    cover property (word_valid && word_ready);
    cover property ($fell(out_enable));
    cover property (strobe && $changed(final_stage));
endmodule : sipo_mon
bind sipo_latch sipo_mon u_sipo_mon (.*);

// ### testbench/sipo_latch_tb_top.sv
`timescale 1ns/100ps
module sipo_latch_tb_top;
    logic core_clk = 0, sys_rst = 1, out_enable = 0, word_ready = 0;
    logic ser_data, shift_clk, strobe, final_stage, final_stage_delayed;
    logic word_valid, word_overflow;
    logic [7:0] parallel_out, parallel_oe, word_data, cas, q[$];
    logic [15:0] sd = 16'h6898;
    logic [7:0] exp_par;
    int n_fail = 0, cmp_count = 0;
    assign cas = {6'h00, final_stage, final_stage_delayed};
    sipo_latch u_sipo_latch (.*);
    sipo_host u_sipo_host (.*);
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    function automatic logic [7:0] shift_in(input logic [7:0] v, input logic b);
        return {v[6:0], b};
    endfunction : shift_in
    task automatic chk(input logic [7:0] seen, exp, input string what);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %s exp %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic final_report;
        $display("checks %0d fails %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : final_report
    initial forever #50 core_clk = ~core_clk;
    initial begin
        repeat (9000) @(posedge core_clk);
        n_fail++;
        final_report();
    end
    initial begin
        repeat (4) @(posedge core_clk);
        sys_rst <= 0;
        out_enable <= 1;
        // ten strobed bytes with no reader overfill the eight-word fifo
        for (int i = 0; i < 10; i++) begin
            sd = lfsr(sd);
            q.push_back(i ? sd[7:0] : 8'h81);
            u_sipo_host.send(q[i], 1);
            chk(parallel_out, q[i], "par");
            chk(cas, {6'h00, {2{q[i][7]}}}, "cas");
        end
        chk(parallel_oe, 8'hff, "oe");
        $display("test shift done");
        out_enable <= 0;
        u_sipo_host.send(8'h81, 0);
        chk(parallel_out, q[9], "hold");
        chk(parallel_oe, 8'h00, "oe off");
        chk(cas, 8'h03, "cas off");
        $display("test hold done");
        for (int i = 0; i < 300 && q.size() > 2; i++) begin
            @(posedge core_clk);
            if ((word_valid & word_ready) === 1'b1)
                chk(word_data, q.pop_front(), "word");
            sd = lfsr(sd);
            word_ready <= sd[0];
        end
        chk({word_overflow, 7'(q.size())}, 8'h82, "fifo");
        $display("test fifo done");
        // strobe held high while shifting: the latch follows every stage
        @(posedge core_clk);
        word_ready <= 1'b0;
        sd = lfsr(sd);
        exp_par = 8'h81;
        for (int i = 7; i >= 0; i--) begin
            u_sipo_host.step({sd[i], 2'h1});
            u_sipo_host.step({sd[i], 2'h3});
            exp_par = shift_in(exp_par, sd[i]);
            chk(parallel_out, exp_par, "transparent");
            chk({7'h00, final_stage}, {7'h00, exp_par[7]}, "tcas");
        end
        u_sipo_host.step(3'h1);
        u_sipo_host.step(3'h0);
        chk({word_valid, word_overflow, 6'h00}, 8'hc0, "tflag");
        chk(word_data, exp_par, "tword");
        $display("test transparent done");
        final_report();
    end
endmodule : sipo_latch_tb_top
